/* File: opp_mem.sv */
`timescale 1ns/10ps
module opp_mem
  import opp_pkg::*;
(
  // clock
  input  wire logic              sys_clk_i,
  // write side
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] waddr_i,
  input  wire logic [7:0]        wdata_i,
  // read side
  input  wire logic [ADDR_W-1:0] raddr_i,
  output logic      [7:0]        rdata_o
);

  // ----------------------------------------------------------------
  // storage, registered read
  // ----------------------------------------------------------------
  logic [7:0] cells [MEM_DEPTH];

  // no reset on the array: an erased part is modelled by preloading
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      cells[waddr_i] <= wdata_i;
    end
    rdata_o <= cells[raddr_i];
  end

endmodule

/* File: opp_pkg.sv */
// How it works
// - access select decodes id, lock, memory
// - access select sampled on latch rising edge
// - upper address captured on latch falling edge
// - address port multiplexes low and upper bits
// - read strobe makes device drive data port
// - write strobe programs byte or lock bits
// - data port bidirectional, direction by strobes
// - select fall latches write strobe, voltage
package opp_pkg;

  // ----------------------------------------------------------------
  // sizes and codes
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 15;
  localparam int          UPPER_W      = 7;
  localparam int          MEM_DEPTH    = 32768;
  localparam logic [1:0]  ACC_RESERVED = 2'h0;
  localparam logic [1:0]  ACC_IDENT    = 2'h1;
  localparam logic [1:0]  ACC_LOCK     = 2'h2;
  localparam logic [1:0]  ACC_MEMORY   = 2'h3;
  localparam logic [1:0]  LOCK_RESET   = 2'h3;
  localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
  // identification bytes: values are arbitrary
  localparam logic [7:0]  IDENT_BYTE0  = 8'h5A;
  localparam logic [7:0]  IDENT_BYTE1  = 8'hA5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ      = 100;
  localparam int          WRITE_STROBE_N_TIME_US = 100;
  localparam int          WRITE_STROBE_N_CYCLES  = WRITE_STROBE_N_TIME_US * CLK_MHZ;
  localparam int          BUSY_W       = 16;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       reset;
    logic       fetch_n;
    logic       select_n;
    logic       sel_hi;
    logic       sel_lo;
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic       vpp;
  } opp_pins_t;

  typedef struct packed {
    logic              is_lock;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } opp_req_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_ARMED,
    ST_ACTIVE
  } opp_state_t;

endpackage

/* File: opp_port.sv */
`timescale 1ns/10ps
module opp_port
  import opp_pkg::*;
#(
  parameter int WRITE_STROBE_N_CYC = WRITE_STROBE_N_CYCLES
)
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // programming mode pins
  input  wire logic       reset_pin_i,
  input  wire logic       code_fetch_strobe_n_i,
  input  wire logic       mode_select_n_i,
  input  wire logic       access_select_hi_i,
  input  wire logic       access_select_lo_i,
  input  wire logic       upper_addr_latch_i,
  input  wire logic       read_strobe_n_i,
  input  wire logic       write_strobe_n_i,
  input  wire logic       write_strobe_n_voltage_in_i,
  input  wire logic       write_strobe_n_level_i,
  // address and data ports
  input  wire logic [7:0] addr_port_i,
  input  wire logic [7:0] data_port_i,
  output logic      [7:0] data_port_o,
  output logic            data_port_oe_n_o,
  // status
  output logic            write_strobe_n_mode_o,
  output logic            write_ready_o,
  output logic            write_strobe_n_busy_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] full_addr(input logic [UPPER_W-1:0] up,
                                                  input logic [7:0] lo);
    full_addr = {up, lo};
  endfunction

  function automatic logic mode_is(input logic [1:0] m, input logic [1:0] code);
    mode_is = (m == code);
  endfunction

  // ----------------------------------------------------------------
  // pin sampling and edges
  // ----------------------------------------------------------------
  opp_pins_t pins;
  opp_pins_t pins_q;
  opp_pins_t next_pins_q;

  assign pins = '{reset: reset_pin_i, fetch_n: code_fetch_strobe_n_i,
                  select_n: mode_select_n_i, sel_hi: access_select_hi_i,
                  sel_lo: access_select_lo_i, ale: upper_addr_latch_i,
                  rd_n: read_strobe_n_i, wr_n: write_strobe_n_i,
                  vpp: write_strobe_n_voltage_in_i};

  logic ale_rise;
  logic ale_fall;
  logic sel_fall;
  logic wr_fall;

  assign ale_rise = pins.ale & ~pins_q.ale;
  assign ale_fall = ~pins.ale & pins_q.ale;
  assign sel_fall = ~pins.select_n & pins_q.select_n;
  assign wr_fall  = ~pins.wr_n & pins_q.wr_n;

  // previous pin levels, so an edge is seen at the first clock that samples the new level
  always_comb begin
    next_pins_q = pins;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pins_q <= '{reset: 1'b0, fetch_n: 1'b1, select_n: 1'b1, sel_hi: 1'b0,
                  sel_lo: 1'b0, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, vpp: 1'b0};
    end else begin
      pins_q <= next_pins_q;
    end
  end

  // ----------------------------------------------------------------
  // mode entry and access selection
  // ----------------------------------------------------------------
  opp_state_t       state;
  opp_state_t       next_state;
  logic             wr_latched;
  logic             next_wr_latched;
  logic             vpp_latched;
  logic             next_vpp_latched;
  logic [1:0]       mode;
  logic [1:0]       next_mode;
  logic [UPPER_W-1:0] upper;
  logic [UPPER_W-1:0] next_upper;
  logic             hold_ok;

  // reset high and fetch strobe low keep the mode alive
  assign hold_ok = pins.reset & ~pins.fetch_n;

  always_comb begin
    next_state       = state;
    next_wr_latched  = wr_latched;
    next_vpp_latched = vpp_latched;
    next_mode        = mode;
    next_upper       = upper;
    unique case (state)
      ST_OFF: begin
        if (hold_ok && pins.select_n) begin
          next_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!hold_ok) begin
          next_state = ST_OFF;
        end else if (sel_fall) begin
          // strobe and voltage levels frozen at the select edge
          next_wr_latched  = pins.wr_n;
          next_vpp_latched = pins.vpp;
          next_mode        = ACC_RESERVED;
          next_state       = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        // a raised select or dropped reset leaves the mode at once
        if (!hold_ok || pins.select_n) begin
          next_state = ST_OFF;
        end
        if (ale_rise) begin
          next_mode = {pins.sel_hi, pins.sel_lo};
        end
        if (ale_fall) begin
          next_upper = addr_port_i[UPPER_W-1:0];
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state       <= ST_OFF;
      wr_latched  <= 1'b0;
      vpp_latched <= 1'b0;
      mode        <= ACC_RESERVED;
      upper       <= '0;
    end else begin
      state       <= next_state;
      wr_latched  <= next_wr_latched;
      vpp_latched <= next_vpp_latched;
      mode        <= next_mode;
      upper       <= next_upper;
    end
  end

  // ----------------------------------------------------------------
  // write capture into a two-entry buffer
  // ----------------------------------------------------------------
  logic     push;
  logic     pop;
  logic     buf_ready;
  opp_req_t push_req;
  opp_req_t buf0;
  opp_req_t buf1;
  opp_req_t next_buf0;
  opp_req_t next_buf1;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic     write_ok;

  // a write needs the strobe latched low, the voltage latched high, the high
  // level present now and a non-reserved, non-identity access
  assign write_ok = (state == ST_ACTIVE) && vpp_latched && !wr_latched && write_strobe_n_level_i &&
                    (mode_is(mode, ACC_MEMORY) || mode_is(mode, ACC_LOCK));
  assign buf_ready = (cnt != 2'h2);
  // a write pulse while the buffer is full is dropped; write_ready_o warns
  assign push = wr_fall && write_ok && buf_ready;
  assign push_req = '{is_lock: mode_is(mode, ACC_LOCK),
                      addr:    full_addr(upper, addr_port_i),
                      data:    data_port_i};

  always_comb begin
    next_buf0 = buf0;
    next_buf1 = buf1;
    next_cnt  = cnt;
    if (pop) begin
      next_buf0 = buf1;
      next_cnt  = cnt - 2'h1;
    end
    if (push) begin
      if (next_cnt == 2'h0) begin
        next_buf0 = push_req;
      end else begin
        next_buf1 = push_req;
      end
      next_cnt = next_cnt + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      buf0 <= '0;
      buf1 <= '0;
      cnt  <= 2'h0;
    end else begin
      buf0 <= next_buf0;
      buf1 <= next_buf1;
      cnt  <= next_cnt;
    end
  end

  // ----------------------------------------------------------------
  // programming engine: one entry per programming time
  // ----------------------------------------------------------------
  logic [BUSY_W-1:0] busy_cnt;
  logic [BUSY_W-1:0] next_busy_cnt;
  logic              mem_we;
  logic              next_mem_we;
  opp_req_t          wr_req;
  opp_req_t          next_wr_req;
  logic [1:0]        lock;
  logic [1:0]        next_lock;

  assign pop = (cnt != 2'h0) && (busy_cnt == '0);

  // lock bits only ever go from one to zero
  always_comb begin
    next_busy_cnt = busy_cnt;
    next_mem_we   = 1'b0;
    next_wr_req   = wr_req;
    next_lock     = lock;
    if (pop) begin
      next_busy_cnt = BUSY_W'(WRITE_STROBE_N_CYC);
      next_wr_req   = buf0;
      if (buf0.is_lock) begin
        next_lock = lock & buf0.data[1:0];
      end else begin
        next_mem_we = 1'b1;
      end
    end else if (busy_cnt != '0) begin
      next_busy_cnt = busy_cnt - BUSY_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      busy_cnt <= '0;
      mem_we   <= 1'b0;
      wr_req   <= '0;
      lock     <= LOCK_RESET;
    end else begin
      busy_cnt <= next_busy_cnt;
      mem_we   <= next_mem_we;
      wr_req   <= next_wr_req;
      lock     <= next_lock;
    end
  end

  logic [7:0] mem_rdata;

  opp_mem u_mem (
    .sys_clk_i (sys_clk_i),
    .we_i      (mem_we),
    .waddr_i   (wr_req.addr),
    .wdata_i   (wr_req.data),
    .raddr_i   (full_addr(upper, addr_port_i)),
    .rdata_o   (mem_rdata)
  );

  // ----------------------------------------------------------------
  // read path and status outputs
  // ----------------------------------------------------------------
  logic [7:0] next_dout;
  logic       next_oe_n;
  logic [7:0] ident;

  assign ident = addr_port_i[0] ? IDENT_BYTE1 : IDENT_BYTE0;

  // reads need no programming voltage; memory data lags the address by
  // two clocks, so the address must settle before the read strobe falls
  always_comb begin
    next_dout = data_port_o;
    next_oe_n = 1'b1;
    if ((state == ST_ACTIVE) && !pins.rd_n && !mode_is(mode, ACC_RESERVED)) begin
      next_oe_n = 1'b0;
      unique case (mode)
        ACC_IDENT:  next_dout = ident;
        ACC_LOCK:   next_dout = {6'h00, lock};
        ACC_MEMORY: next_dout = mem_rdata;
        default:    next_dout = ERASED_BYTE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      data_port_o      <= 8'h00;
      data_port_oe_n_o <= 1'b1;
      write_strobe_n_mode_o      <= 1'b0;
      write_ready_o    <= 1'b0;
      write_strobe_n_busy_o      <= 1'b0;
    end else begin
      data_port_o      <= next_dout;
      data_port_oe_n_o <= next_oe_n;
      write_strobe_n_mode_o      <= (next_state == ST_ACTIVE);
      write_ready_o    <= (next_cnt != 2'h2);
      write_strobe_n_busy_o      <= (next_busy_cnt != '0) || (next_cnt != 2'h0);
    end
  end

endmodule

/* File: opp_port_props.sv */
`timescale 1ns/10ps
module opp_port_props
  import opp_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  // mode and strobe pins
  input wire logic       reset_pin_i,
  input wire logic       code_fetch_strobe_n_i,
  input wire logic       mode_select_n_i,
  input wire logic       access_select_hi_i,
  input wire logic       access_select_lo_i,
  input wire logic       upper_addr_latch_i,
  input wire logic       read_strobe_n_i,
  input wire logic       write_strobe_n_i,
  input wire logic       write_strobe_n_voltage_in_i,
  input wire logic       write_strobe_n_level_i,
  // ports and status
  input wire logic [7:0] addr_port_i,
  input wire logic [7:0] data_port_o,
  input wire logic       data_port_oe_n_o,
  input wire logic       write_strobe_n_mode_o,
  input wire logic       write_ready_o,
  input wire logic       write_strobe_n_busy_o
);
  logic       ale_q, sel_q, vpp_q, wr_q, bad_wr;
  logic [1:0] acc;
  // shadow of code, voltage and strobe; code cleared outside the mode as entry clears it
  always_ff @(posedge sys_clk_i) begin
    ale_q <= upper_addr_latch_i;
    sel_q <= mode_select_n_i;
    if (sel_q && !mode_select_n_i) vpp_q <= write_strobe_n_voltage_in_i;
    if (sel_q && !mode_select_n_i) wr_q <= write_strobe_n_i;
    if (!rst_n_i || !write_strobe_n_mode_o) acc <= ACC_RESERVED;
    else if (upper_addr_latch_i && !ale_q) acc <= {access_select_hi_i, access_select_lo_i};
  end
  assign bad_wr = acc < ACC_LOCK || !write_strobe_n_level_i || !vpp_q || wr_q;
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_oe_release: assert property (read_strobe_n_i[*3] |-> data_port_oe_n_o)
    else $error("data port driven with read strobe high");
  a_read_cause: assert property ($fell(data_port_oe_n_o) |->
    write_strobe_n_mode_o && !$past(read_strobe_n_i))
    else $error("data port driven without a read");
  a_reserved_mute: assert property (acc == ACC_RESERVED &&
    $past(acc) == ACC_RESERVED |-> data_port_oe_n_o)
    else $error("data port driven in reserved mode");
  a_ident_bytes: assert property (!data_port_oe_n_o && acc == ACC_IDENT |->
    data_port_o == (addr_port_i[0] ? IDENT_BYTE1 : IDENT_BYTE0))
    else $error("wrong identification byte");
  a_lock_upper: assert property (!data_port_oe_n_o && acc == ACC_LOCK |->
    data_port_o[7:2] == 6'h00)
    else $error("lock read upper bits set");
  a_write_refused: assert property ($fell(write_strobe_n_i) && !write_strobe_n_busy_o && bad_wr
    |-> ##1 !write_strobe_n_busy_o[*4])
    else $error("refused write started programming");
  a_write_taken: assert property ($fell(write_strobe_n_i) && write_strobe_n_mode_o
    && write_ready_o && !bad_wr |-> ##[1:3] write_strobe_n_busy_o)
    else $error("write not taken");
  a_busy_span: assert property ($rose(write_strobe_n_busy_o) |-> write_strobe_n_busy_o[*4])
    else $error("programming time too short");
  a_mode_entry: assert property ($fell(mode_select_n_i) && reset_pin_i
    && $past(reset_pin_i) && !code_fetch_strobe_n_i && !$past(code_fetch_strobe_n_i)
    |-> ##[1:3] write_strobe_n_mode_o)
    else $error("mode not entered");
  a_mode_exit: assert property (write_strobe_n_mode_o && !reset_pin_i |-> ##[1:3] !write_strobe_n_mode_o)
    else $error("mode not left");
endmodule
bind opp_port opp_port_props i_props (.sys_clk_i, .rst_n_i, .reset_pin_i, .code_fetch_strobe_n_i,
  .mode_select_n_i, .access_select_hi_i, .access_select_lo_i, .upper_addr_latch_i,
  .read_strobe_n_i, .write_strobe_n_i, .write_strobe_n_voltage_in_i, .write_strobe_n_level_i, .addr_port_i,
  .data_port_o, .data_port_oe_n_o, .write_strobe_n_mode_o, .write_ready_o, .write_strobe_n_busy_o);

/* File: opp_write_strobe_n_model.sv */
`timescale 1ns/10ps
module opp_write_strobe_n_model
  import opp_pkg::*;
(
  // clock
  input  wire logic       sys_clk_i,
  // data line as the programmer sees it
  input  wire logic [7:0] bus_i,
  // lines toward the device
  output opp_pins_t       pins_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] data_o,
  output logic            lvl_o
);
  logic [7:0] wdat;
  logic       drv;
  // a released data line shows the inverse of the last byte, never a stale copy
  assign data_o = drv ? wdat : ~wdat;
  // reset 1, fetch 0, select 1, code 01, latch 0, read 1, write 0, voltage 0
  initial begin
    pins_o = 9'h154;
    addr_o = 8'h00;
    wdat = 8'h00;
    drv = 1'b0;
    lvl_o = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic level(input logic v);
    lvl_o = v;
  endtask
  // voltage and strobe levels chosen per call so a scenario can enter wrongly
  task automatic enter(input logic v, input logic w);
    pins_o.reset = 1'b1;
    pins_o.select_n = 1'b1;
    pins_o.wr_n = w;
    pins_o.vpp = v;
    step(2);
    pins_o.select_n = 1'b0;
    step(2);
    pins_o.wr_n = 1'b1;
    step(2);
  endtask
  task automatic leave();
    pins_o.reset = 1'b0;
    step(4);
  endtask
  // code changes only with the latch low; every mode change gets a new pulse
  task automatic latch(input logic [1:0] m, input logic [6:0] up);
    {pins_o.sel_hi, pins_o.sel_lo} = m;
    addr_o = {1'b0, up};
    step(2);
    pins_o.ale = 1'b1;
    step(2);
    pins_o.ale = 1'b0;
    step(2);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_o = a;
    wdat = d;
    drv = 1'b1;
    step(1);
    pins_o.wr_n = 1'b0;
    step(1);
    pins_o.wr_n = 1'b1;
    step(1);
    drv = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_o = a;
    step(3);
    pins_o.rd_n = 1'b0;
    step(3);
    d = bus_i;
    pins_o.rd_n = 1'b1;
    step(2);
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import opp_pkg::*;
  localparam int PC = 12;
  logic       sys_clk_i, rst_n_i, lvl, oe_n, mode_o, rdy, busy;
  logic       full = 1'b0;
  opp_pins_t  p;
  logic [7:0] addr, pdat, ddat, bus;
  logic [7:0] img [logic [14:0]];
  int         fail_count = 0;
  int         cmp_count = 0;
  // the device drives the data line only while its enable is low
  assign bus = oe_n ? pdat : ddat;
  opp_write_strobe_n_model i_write_strobe_n (.sys_clk_i, .bus_i(bus), .pins_o(p), .addr_o(addr), .data_o(pdat),
    .lvl_o(lvl));
  opp_port #(.WRITE_STROBE_N_CYC(PC)) i_dut (.sys_clk_i, .rst_n_i, .reset_pin_i(p.reset),
    .code_fetch_strobe_n_i(p.fetch_n), .mode_select_n_i(p.select_n),
    .access_select_hi_i(p.sel_hi), .access_select_lo_i(p.sel_lo), .upper_addr_latch_i(p.ale),
    .read_strobe_n_i(p.rd_n), .write_strobe_n_i(p.wr_n), .write_strobe_n_voltage_in_i(p.vpp),
    .write_strobe_n_level_i(lvl), .addr_port_i(addr), .data_port_i(bus), .data_port_o(ddat),
    .data_port_oe_n_o(oe_n), .write_strobe_n_mode_o(mode_o), .write_ready_o(rdy), .write_strobe_n_busy_o(busy));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // remembers whether the write buffer ever pushed back
  always @(posedge sys_clk_i) if (mode_o === 1'b1 && rdy === 1'b0) full <= 1'b1;
  task automatic check(input string n, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // bounded wait for an empty engine or a free buffer slot
  task automatic wait_idle(input logic drained);
    int n;
    n = 0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    while ((drained ? busy !== 1'b0 : rdy !== 1'b1) && n < 500) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    check("wait bound", {7'h00, n >= 500}, 8'h00);
  endtask
  initial begin
    #400us;
    fail_count++;
    summarize();
  end
  initial begin
    int          i;
    int          cur;
    logic [6:0]  up;
    logic [7:0]  d;
    logic [7:0]  lk;
    logic [14:0] a0;
    void'($urandom(32'hB1EFE390));
    rst_n_i = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    #1;
    check("oe reset", {7'h00, oe_n}, 8'h01);
    rst_n_i = 1'b1;
    i_write_strobe_n.enter(1'b1, 1'b0);
    check("mode entered", {7'h00, mode_o}, 8'h01);
    // writes across a page boundary, fast enough to fill the buffer
    up = 7'($urandom);
    for (i = 0; i < 6; i++) begin
      if (i % 3 == 0) i_write_strobe_n.latch(ACC_MEMORY, up + 7'(i / 3));
      d = 8'($urandom);
      wait_idle(1'b0);
      i_write_strobe_n.wr(8'hFD + 8'(i), d);
      img[{up + 7'(i / 3), 8'hFD + 8'(i)}] = d;
    end
    wait_idle(1'b1);
    check("buffer full seen", {7'h00, full}, 8'h01);
    cur = -1;
    foreach (img[a]) begin
      if (int'(a[14:8]) != cur) i_write_strobe_n.latch(ACC_MEMORY, a[14:8]);
      cur = int'(a[14:8]);
      i_write_strobe_n.rd(a[7:0], d);
      check("memory byte", d, img[a]);
    end
    a0 = {up, 8'hFD};
    i_write_strobe_n.latch(ACC_MEMORY, up);
    i_write_strobe_n.level(1'b0);
    i_write_strobe_n.wr(8'hFD, ~img[a0]);
    i_write_strobe_n.level(1'b1);
    wait_idle(1'b1);
    i_write_strobe_n.rd(8'hFD, d);
    check("low level write", d, img[a0]);
    i_write_strobe_n.latch(ACC_IDENT, 7'h00);
    i_write_strobe_n.wr(8'h00, 8'h00);
    for (i = 0; i < 2; i++) begin
      i_write_strobe_n.rd(8'(i), d);
      check("ident byte", d, i ? IDENT_BYTE1 : IDENT_BYTE0);
    end
    i_write_strobe_n.latch(ACC_RESERVED, 7'h00);
    i_write_strobe_n.wr(8'h5C, 8'h3C);
    i_write_strobe_n.rd(8'h00, d);
    check("reserved read", d, 8'hC3);
    i_write_strobe_n.latch(ACC_LOCK, 7'h00);
    lk = {6'h00, LOCK_RESET};
    for (i = 0; i < 2; i++) begin
      d = 8'($urandom);
      i_write_strobe_n.wr(8'h00, d);
      lk = lk & {6'h3F, d[1:0]};
      wait_idle(1'b1);
      i_write_strobe_n.rd(8'h00, d);
      check("lock bits", d, lk);
    end
    i_write_strobe_n.leave();
    check("mode left", {7'h00, mode_o}, 8'h00);
    i_write_strobe_n.enter(1'b0, 1'b0);
    i_write_strobe_n.latch(ACC_MEMORY, up);
    i_write_strobe_n.wr(8'hFD, ~img[a0]);
    wait_idle(1'b1);
    i_write_strobe_n.rd(8'hFD, d);
    check("no voltage write", d, img[a0]);
    // entry with the write strobe high must leave every later write refused
    i_write_strobe_n.leave();
    i_write_strobe_n.enter(1'b1, 1'b1);
    i_write_strobe_n.latch(ACC_MEMORY, up);
    i_write_strobe_n.wr(8'hFD, ~img[a0]);
    wait_idle(1'b1);
    i_write_strobe_n.rd(8'hFD, d);
    check("strobe latched high", d, img[a0]);
    summarize();
  end
endmodule
